// file: ptc_cmd_status.sv
// paper tape reader/punch command decode and status reporting
// Functional notes
// - status bit 0 late-unload, 3 no-motion, 4 busy, 5 more-status, 7 device-absent
// - command bits 0..7 disable enable stop run single_step_command slew write read, combinable
// - reader mode: device-absent when reader in load mode or ac power off
// - punch mode: device-absent when punch local or low tape sensed
// - reader busy drops on character strobe, rises on host data request
// - punch busy sets on host character load until strobed to punch
// - busy held about one second after punch power applied
// - no-motion set when tape-run and feed flip-flops both clear
// - after stop, no-motion shows once tape halts on next character
// - write mode forces late-unload, no-motion, more-status to zero
// - slew mode: character arriving before previous requested sets late-unload
// - incremental mode restarts tape only on unloading data request
// - end-of-media status bit is never driven
// - command flip-flops load only when strobe coincides with selected state
// - read command clears write-select; write sets write-select, power, attention
// - tape moves while run set; slew picks continuous or single step
// - gated command with bit 1 sets interrupt permit
// - bit 0 clears permit unless bit 1 also set; attention still saved but not presented
// - attention saved on reader char, write entry, punch done; shown if permitted
// - initialize line clears all flip-flops except device-transmit, which sets
// - any mode command clears buffer-full and, unless the same byte sets them, permit, run, slew; sets transmit; read clears attention
`timescale 1ns/1ps
`include "ptc_cfg.svh"

module ptc_cmd_status
    import ptc_pkg::*;
#(
    parameter int WARMUP_CYC = `PTC_WARMUP_CYC
) (
    // clock and reset
    input  wire logic       i_core_clk,
    input  wire logic       i_resetn,
    // host bus
    input  wire logic [7:0] i_host_out_lines,
    input  wire logic       i_command_strobe_n,
    input  wire logic       i_selected,
    input  wire logic       i_data_request_line,
    input  wire logic       i_data_avail_line,
    input  wire logic       i_init_line_n,
    input  wire logic       i_attn_ack,
    // reader side
    input  wire logic       i_reader_strobe,
    input  wire logic       i_reader_load_mode,
    input  wire logic       i_reader_ac_off,
    // punch side
    input  wire logic       i_punch_local,
    input  wire logic       i_punch_low_tape,
    input  wire logic       i_punch_power_ok,
    input  wire logic       i_punch_done,
    // status and attention
    output logic [7:0]      o_status_byte,
    output logic            o_attention,
    // controls to mechanisms
    output logic            o_tape_run_ff,
    output logic            o_feed_ff,
    output logic            o_continuous_feed_select,
    output logic            o_write_select_ff,
    output logic            o_punch_power_ff,
    output logic            o_irq_permit_ff,
    output logic            o_device_transmit_ff
);

    localparam int CW = $clog2(WARMUP_CYC + 1);

    // two-stage synchroniser plus history for edges
    logic [`PTC_PIN_COUNT-1:0] pin_raw;
    logic [`PTC_PIN_COUNT-1:0] pin_meta_reg;
    logic [`PTC_PIN_COUNT-1:0] pin_sync_reg;
    logic [`PTC_PIN_COUNT-1:0] pin_prev_reg;
    ptc_byte_t                 lines_meta_reg;
    ptc_byte_t                 lines_sync_reg;

    function automatic logic rise(input logic prev, input logic cur);
        return cur & ~prev;
    endfunction : rise

    function automatic ptc_mode_t mode_of(input logic wsel);
        return wsel ? PTC_MODE_WRITE : PTC_MODE_READ;
    endfunction : mode_of

    assign pin_raw = {i_data_avail_line, i_punch_done, i_punch_power_ok, i_punch_low_tape,
                      i_punch_local, i_reader_ac_off, i_reader_load_mode, i_reader_strobe,
                      i_init_line_n, i_data_request_line, i_command_strobe_n};

    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            pin_meta_reg   <= `PTC_PIN_IDLE;
            pin_sync_reg   <= `PTC_PIN_IDLE;
            pin_prev_reg   <= `PTC_PIN_IDLE;
            lines_meta_reg <= 8'h00;
            lines_sync_reg <= 8'h00;
        end else begin
            pin_meta_reg   <= pin_raw;
            pin_sync_reg   <= pin_meta_reg;
            pin_prev_reg   <= pin_sync_reg;
            lines_meta_reg <= i_host_out_lines;
            lines_sync_reg <= lines_meta_reg;
        end
    end

    // decoded events
    logic      init;
    logic      cmd_gate;
    logic      dreq_ev;
    logic      rstrb_ev;
    logic      pdone_ev;
    logic      davail_ev;
    logic      wmode;
    ptc_byte_t cb;
    logic      mode_cmd;
    logic      write_cmd;
    logic      warm_done;
    logic      warm_end_ev;
    logic      clear_all;

    assign init      = ~pin_sync_reg[`PTC_PIN_INIT_N];
    assign clear_all = ~i_resetn | init;
    assign cmd_gate  = rise(pin_sync_reg[`PTC_PIN_CMD_N], pin_prev_reg[`PTC_PIN_CMD_N])
                       & i_selected;
    assign dreq_ev   = rise(pin_prev_reg[`PTC_PIN_DREQ], pin_sync_reg[`PTC_PIN_DREQ]);
    assign rstrb_ev  = rise(pin_prev_reg[`PTC_PIN_RSTRB], pin_sync_reg[`PTC_PIN_RSTRB]);
    assign pdone_ev  = rise(pin_prev_reg[`PTC_PIN_PDONE], pin_sync_reg[`PTC_PIN_PDONE]);
    assign davail_ev = rise(pin_prev_reg[`PTC_PIN_DAVAIL], pin_sync_reg[`PTC_PIN_DAVAIL]);
    assign wmode     = (mode_of(o_write_select_ff) == PTC_MODE_WRITE);
    assign cb        = lines_sync_reg;
    assign write_cmd = cmd_gate & cb[`PTC_CB_WRITE];
    assign mode_cmd  = cmd_gate & (cb[`PTC_CB_WRITE] | cb[`PTC_CB_READ]);

    // mode select and punch power
    always_ff @(posedge i_core_clk) begin
        if (clear_all) begin
            o_write_select_ff <= 1'b0;
            o_punch_power_ff  <= 1'b0;
        end else if (cmd_gate) begin
            if (cb[`PTC_CB_WRITE]) begin
                o_write_select_ff <= 1'b1;
                o_punch_power_ff  <= 1'b1;
            end else if (cb[`PTC_CB_READ]) begin
                o_write_select_ff <= 1'b0;
                o_punch_power_ff  <= 1'b0;
            end else if (o_write_select_ff && cb[`PTC_CB_STOP]) begin
                o_punch_power_ff  <= 1'b0;
            end else if (o_write_select_ff && cb[`PTC_CB_RUN]) begin
                o_punch_power_ff  <= 1'b1;
            end
        end
    end

    // interrupt permit
    always_ff @(posedge i_core_clk) begin
        if (clear_all) begin
            o_irq_permit_ff <= 1'b0;
        end else if (cmd_gate && cb[`PTC_CB_ENABLE]) begin
            o_irq_permit_ff <= 1'b1;
        end else if (cmd_gate && (cb[`PTC_CB_DISABLE] || mode_cmd)) begin
            o_irq_permit_ff <= 1'b0;
        end
    end

    // tape run, reader side only, and slew select, set in either mode
    always_ff @(posedge i_core_clk) begin
        if (clear_all) begin
            o_tape_run_ff            <= 1'b0;
            o_continuous_feed_select <= 1'b0;
        end else if (cmd_gate) begin
            if (cb[`PTC_CB_SLEW]) begin
                o_continuous_feed_select <= 1'b1;
            end else if (cb[`PTC_CB_SINGLE_STEP_COMMAND] || mode_cmd) begin
                o_continuous_feed_select <= 1'b0;
            end
            if (cb[`PTC_CB_RUN] && !write_cmd && !(wmode && !cb[`PTC_CB_READ])) begin
                o_tape_run_ff <= 1'b1;
            end else if (cb[`PTC_CB_STOP] || mode_cmd) begin
                o_tape_run_ff <= 1'b0;
            end
        end
    end

    // feed flip-flop: slew keeps feeding, step stops on each character
    logic run_start;
    assign run_start = cmd_gate & cb[`PTC_CB_RUN] & ~wmode & ~write_cmd;

    always_ff @(posedge i_core_clk) begin
        if (clear_all || wmode) begin
            o_feed_ff <= 1'b0;
        end else if (run_start) begin
            o_feed_ff <= 1'b1;
        end else if (dreq_ev && o_tape_run_ff && !o_continuous_feed_select) begin
            o_feed_ff <= 1'b1;
        end else if (o_tape_run_ff && o_continuous_feed_select) begin
            o_feed_ff <= 1'b1;
        end else if (rstrb_ev) begin
            o_feed_ff <= 1'b0;
        end
    end

    // device transmit: low while an unrequested character is held
    always_ff @(posedge i_core_clk) begin
        if (clear_all) begin
            o_device_transmit_ff <= 1'b1;
        end else if (mode_cmd) begin
            o_device_transmit_ff <= 1'b1;
        end else if (!wmode && rstrb_ev) begin
            o_device_transmit_ff <= 1'b0;
        end else if (!wmode && dreq_ev) begin
            o_device_transmit_ff <= 1'b1;
        end
    end

    // late unload: new character before the last was taken, slew mode
    logic late_reg;

    always_ff @(posedge i_core_clk) begin
        if (clear_all || mode_cmd) begin
            late_reg <= 1'b0;
        end else if (!wmode && rstrb_ev && !o_device_transmit_ff
                     && o_continuous_feed_select) begin
            late_reg <= 1'b1;
        end
    end

    // punch buffer full
    logic buf_full_reg;

    always_ff @(posedge i_core_clk) begin
        if (clear_all || mode_cmd) begin
            buf_full_reg <= 1'b0;
        end else if (wmode && davail_ev && !buf_full_reg) begin
            buf_full_reg <= 1'b1;
        end else if (pdone_ev) begin
            buf_full_reg <= 1'b0;
        end
    end

    // punch warm-up timer, recycled whenever power drops
    logic [CW-1:0] warm_cnt_reg;

    assign warm_done   = (warm_cnt_reg == CW'(WARMUP_CYC));
    assign warm_end_ev = (warm_cnt_reg == CW'(WARMUP_CYC - 1));

    always_ff @(posedge i_core_clk) begin
        if (clear_all || !o_punch_power_ff || !pin_sync_reg[`PTC_PIN_PPWROK]) begin
            warm_cnt_reg <= '0;
        end else if (!warm_done) begin
            warm_cnt_reg <= warm_cnt_reg + CW'(1);
        end
    end

    // attention: set wins over mode-command and acknowledge clears, reset and initialize win over set
    logic attn_reg;
    logic attn_set;

    assign attn_set = (!wmode && rstrb_ev) || write_cmd
                      || (wmode && pdone_ev && buf_full_reg)
                      || (o_punch_power_ff && warm_end_ev);

    always_ff @(posedge i_core_clk) begin
        if (clear_all) begin
            attn_reg <= 1'b0;
        end else if (attn_set) begin
            attn_reg <= 1'b1;
        end else if (mode_cmd || i_attn_ack) begin
            attn_reg <= 1'b0;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (clear_all) begin
            o_attention <= 1'b0;
        end else begin
            o_attention <= attn_reg & o_irq_permit_ff;
        end
    end

    // status byte assembly
    logic      absent;
    logic      busy;
    logic      nomotion;
    ptc_byte_t status_next;

    always_comb begin
        status_next = 8'h00;
        if (wmode) begin
            absent = pin_sync_reg[`PTC_PIN_PLOCAL] | pin_sync_reg[`PTC_PIN_PLOW];
            busy   = buf_full_reg | (o_punch_power_ff & ~warm_done);
            nomotion = 1'b0;
        end else begin
            absent = pin_sync_reg[`PTC_PIN_RLOAD] | pin_sync_reg[`PTC_PIN_RACOFF];
            busy   = o_device_transmit_ff;
            nomotion = ~o_tape_run_ff & ~o_feed_ff;
        end
        status_next[`PTC_ST_LATE]     = late_reg & ~wmode;
        status_next[`PTC_ST_NOMOTION] = nomotion;
        status_next[`PTC_ST_BUSY]     = busy;
        status_next[`PTC_ST_MORE]     = ~wmode & (late_reg | nomotion);
        status_next[`PTC_ST_ABSENT]   = absent;
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            o_status_byte <= `PTC_STATUS_RST;
        end else begin
            o_status_byte <= status_next;
        end
    end

    // checks
    default clocking cb_chk @(posedge i_core_clk); endclocking
    default disable iff (!i_resetn);

    chk_status_zero_bits: assert property (
        o_status_byte[1] == 1'b0 && o_status_byte[2] == 1'b0 && o_status_byte[6] == 1'b0)
        else $error("undefined status bit set");

    chk_write_mode_quiet: assert property (
        wmode && $past(wmode) && !init |=> o_status_byte[`PTC_ST_LATE] == 1'b0
            && o_status_byte[`PTC_ST_NOMOTION] == 1'b0 && o_status_byte[`PTC_ST_MORE] == 1'b0)
        else $error("write mode shows reader flags");

    chk_more_summary: assert property (
        o_status_byte[`PTC_ST_MORE] ==
            (o_status_byte[`PTC_ST_LATE] | o_status_byte[`PTC_ST_NOMOTION]))
        else $error("more-status does not summarise");

    chk_cmd_needs_sel: assert property (
        !i_selected && !init |=> $stable(o_irq_permit_ff) && $stable(o_tape_run_ff))
        else $error("command taken while not selected");

    chk_enable_sets: assert property (
        cmd_gate && cb[`PTC_CB_ENABLE] && !init |=> o_irq_permit_ff)
        else $error("enable command ignored");

    chk_disable_clears: assert property (
        cmd_gate && cb[`PTC_CB_DISABLE] && !cb[`PTC_CB_ENABLE] |=> !o_irq_permit_ff
            ##1 !o_attention)
        else $error("disable command ignored");

    chk_mode_partial: assert property (
        mode_cmd && !init |=> o_device_transmit_ff && !buf_full_reg
            && !o_continuous_feed_select == !cb[`PTC_CB_SLEW])
        else $error("mode command partial clear wrong");

    chk_write_entry: assert property (
        write_cmd && !init |=> o_write_select_ff && o_punch_power_ff && attn_reg)
        else $error("write command effects missing");

    chk_init_clear: assert property (
        init |=> o_device_transmit_ff && !o_tape_run_ff && !attn_reg && !o_write_select_ff)
        else $error("initialize did not clear");

    chk_reader_busy_drop: assert property (
        !wmode && rstrb_ev && !mode_cmd && !init && !$past(init) |=> !o_device_transmit_ff
            ##1 !o_status_byte[`PTC_ST_BUSY] || o_write_select_ff)
        else $error("reader busy did not drop");

    chk_warmup_busy: assert property (
        o_punch_power_ff && wmode && !warm_done && !init |=> o_status_byte[`PTC_ST_BUSY])
        else $error("busy not held during warm-up");

    cov_write_entry: cover property (write_cmd ##[1:20] o_attention);
    cov_late_unload: cover property (o_status_byte[`PTC_ST_LATE]);
    cov_step_restart: cover property (dreq_ev && o_tape_run_ff && !o_continuous_feed_select);
    cov_punch_done: cover property (wmode && pdone_ev && buf_full_reg);

endmodule : ptc_cmd_status

// file: ptc_cfg.svh
// constants for the paper tape command and status block
`ifndef PTC_CFG_SVH
`define PTC_CFG_SVH

// status byte bit positions
`define PTC_ST_LATE      0
`define PTC_ST_NOMOTION  3
`define PTC_ST_BUSY      4
`define PTC_ST_MORE      5
`define PTC_ST_EOM       6
`define PTC_ST_ABSENT    7

// command byte bit positions
`define PTC_CB_DISABLE   0
`define PTC_CB_ENABLE    1
`define PTC_CB_STOP      2
`define PTC_CB_RUN       3
`define PTC_CB_SINGLE_STEP_COMMAND      4
`define PTC_CB_SLEW      5
`define PTC_CB_WRITE     6
`define PTC_CB_READ      7

// synchronised pin vector positions
`define PTC_PIN_CMD_N    0
`define PTC_PIN_DREQ     1
`define PTC_PIN_INIT_N   2
`define PTC_PIN_RSTRB    3
`define PTC_PIN_RLOAD    4
`define PTC_PIN_RACOFF   5
`define PTC_PIN_PLOCAL   6
`define PTC_PIN_PLOW     7
`define PTC_PIN_PPWROK   8
`define PTC_PIN_PDONE    9
`define PTC_PIN_DAVAIL   10
`define PTC_PIN_COUNT    11
`define PTC_PIN_IDLE     11'h005

// reset values
`define PTC_STATUS_RST   8'h00

// timing
`define PTC_CLK_PERIOD_NS 20
`define PTC_WARMUP_MS     1000
`define PTC_WARMUP_CYC    ((`PTC_WARMUP_MS * 1000000) / `PTC_CLK_PERIOD_NS)

`endif

// file: ptc_pkg.sv
// types for the paper tape command and status block
package ptc_pkg;
    typedef logic [7:0] ptc_byte_t;
    typedef enum logic {
        PTC_MODE_READ,
        PTC_MODE_WRITE
    } ptc_mode_t;
endpackage : ptc_pkg

// file: ptc_host_model.sv
// host processor model: command bytes, data requests, data available, initialize
`timescale 1ns/1ps
module ptc_host_model
    import ptc_pkg::*;
(
    // clock
    input  wire logic i_core_clk,
    // host bus lines
    output ptc_byte_t  o_host_out_lines,
    output logic       o_command_strobe_n,
    output logic       o_selected,
    output logic       o_data_request_line,
    output logic       o_data_avail_line,
    output logic       o_init_line_n
);
    initial begin
        o_host_out_lines    = 8'h5A;
        o_command_strobe_n  = 1'b1;
        o_selected          = 1'b0;
        o_data_request_line = 1'b0;
        o_data_avail_line   = 1'b0;
        o_init_line_n       = 1'b1;
    end

    // lines settle first, strobe pulses while select is held at sel, then lines are inverted and select dropped
    task automatic cmd(input ptc_byte_t val, input logic sel);
        @(negedge i_core_clk);
        o_host_out_lines = val;
        o_selected       = sel;
        repeat (4) @(negedge i_core_clk);
        o_command_strobe_n = 1'b0;
        repeat (4) @(negedge i_core_clk);
        o_command_strobe_n = 1'b1;
        repeat (4) @(negedge i_core_clk);
        o_host_out_lines = ~val;
        o_selected       = 1'b0;
        repeat (4) @(negedge i_core_clk);
    endtask : cmd

    // which: 0 data request, 1 data available, 2 initialize
    task automatic line_pulse(input int which);
        @(negedge i_core_clk);
        o_data_request_line = (which == 0);
        o_data_avail_line   = (which == 1);
        o_init_line_n       = (which != 2);
        repeat (6) @(negedge i_core_clk);
        o_data_request_line = 1'b0;
        o_data_avail_line   = 1'b0;
        o_init_line_n       = 1'b1;
        repeat (8) @(negedge i_core_clk);
    endtask : line_pulse
endmodule : ptc_host_model

// file: tb_ptc_cmd_status.sv
// self-checking bench for the paper tape command and status block
`timescale 1ns/1ps
module tb_ptc_cmd_status;
    import ptc_pkg::*;
    logic      clk      = 1'b0;
    logic      rstn     = 1'b0;
    logic      rd_strb  = 1'b0;
    logic      rd_load  = 1'b0;
    logic      rd_acoff = 1'b0;
    logic      p_local  = 1'b0;
    logic      p_low    = 1'b0;
    logic      p_pwrok  = 1'b0;
    logic      p_done   = 1'b0;
    logic      ack      = 1'b0;
    ptc_byte_t host_lines;
    ptc_byte_t status;
    logic      cmd_n, sel, dreq, davail, init_n, attn;
    logic      run, feed, slew, wsel, punch_power_ff, permit, xmit;
    int        failures        = 0;
    int        samples_checked = 0;
    int        n;

    always #10 clk = ~clk;

    ptc_host_model host_u (.i_core_clk(clk), .o_host_out_lines(host_lines),
        .o_command_strobe_n(cmd_n), .o_selected(sel), .o_data_request_line(dreq),
        .o_data_avail_line(davail), .o_init_line_n(init_n));

    ptc_cmd_status #(.WARMUP_CYC(20)) dut_u (.i_core_clk(clk), .i_resetn(rstn),
        .i_host_out_lines(host_lines), .i_command_strobe_n(cmd_n), .i_selected(sel),
        .i_data_request_line(dreq), .i_data_avail_line(davail), .i_init_line_n(init_n),
        .i_attn_ack(ack), .i_reader_strobe(rd_strb), .i_reader_load_mode(rd_load),
        .i_reader_ac_off(rd_acoff), .i_punch_local(p_local), .i_punch_low_tape(p_low),
        .i_punch_power_ok(p_pwrok), .i_punch_done(p_done), .o_status_byte(status),
        .o_attention(attn), .o_tape_run_ff(run), .o_feed_ff(feed),
        .o_continuous_feed_select(slew), .o_write_select_ff(wsel),
        .o_punch_power_ff(punch_power_ff), .o_irq_permit_ff(permit), .o_device_transmit_ff(xmit));

    task automatic chk(input ptc_byte_t seen, input ptc_byte_t exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // mechanism pin pulse, then let synchronisers and status settle
    task automatic pulse(ref logic sig, input int len);
        @(negedge clk);
        sig = 1'b1;
        repeat (len) @(negedge clk);
        sig = 1'b0;
        repeat (8) @(negedge clk);
    endtask : pulse

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (16) @(negedge clk);
        rstn = 1'b1;
        repeat (4) @(negedge clk);
        chk(status, 8'h38);
        $display("test reset done");
        host_u.cmd(8'hAA, 1'b1);
        chk({4'h0, run, slew, wsel, permit}, 8'h0D);
        chk(status, 8'h10);
        pulse(rd_strb, 4);
        chk(status, 8'h00);
        chk({6'h00, attn, xmit}, 8'h02);
        pulse(rd_strb, 4);
        chk(status, 8'h21);
        host_u.line_pulse(0);
        chk(status, 8'h31);
        host_u.cmd(8'h01, 1'b1);
        chk({6'h00, permit, attn}, 8'h00);
        host_u.cmd(8'h02, 1'b1);
        chk({6'h00, permit, attn}, 8'h03);
        host_u.cmd(8'h05, 1'b0);
        chk({6'h00, run, permit}, 8'h03);
        $display("test slew done");
        pulse(rd_strb, 4);
        host_u.cmd(8'h98, 1'b1);
        chk({2'h0, attn, permit, slew, xmit, run, feed}, 8'h07);
        chk(status, 8'h10);
        pulse(rd_strb, 4);
        chk({6'h00, run, feed}, 8'h02);
        host_u.line_pulse(0);
        chk({6'h00, run, feed}, 8'h03);
        host_u.cmd(8'h04, 1'b1);
        chk(status, 8'h10);
        pulse(rd_strb, 4);
        chk(status, 8'h28);
        for (n = 0; n < 2; n++) begin
            @(negedge clk);
            rd_load  = (n == 0);
            rd_acoff = (n == 1);
            repeat (6) @(negedge clk);
            chk(status, 8'hA8);
        end
        rd_acoff = 1'b0;
        $display("test step done");
        host_u.cmd(8'h4A, 1'b1);
        chk({4'h0, wsel, punch_power_ff, permit, attn}, 8'h0F);
        chk(status, 8'h10);
        pulse(ack, 1);
        p_pwrok = 1'b1;
        n = 0;
        while (status[4] !== 1'b0 && n < 200) begin
            @(negedge clk);
            n++;
        end
        if (n >= 200) begin
            failures++;
        end
        chk({7'h00, (n >= 18 && n <= 30)}, 8'h01);
        repeat (4) @(negedge clk);
        chk(status, 8'h00);
        chk({7'h00, attn}, 8'h01);
        pulse(ack, 1);
        host_u.line_pulse(1);
        chk(status, 8'h10);
        chk({7'h00, attn}, 8'h00);
        pulse(p_done, 4);
        chk(status, 8'h00);
        chk({7'h00, attn}, 8'h01);
        for (n = 0; n < 2; n++) begin
            @(negedge clk);
            p_local = (n == 0);
            p_low   = (n == 1);
            repeat (6) @(negedge clk);
            chk(status, 8'h80);
        end
        p_low = 1'b0;
        host_u.cmd(8'h04, 1'b1);
        chk({6'h00, wsel, punch_power_ff}, 8'h02);
        host_u.cmd(8'h08, 1'b1);
        chk({6'h00, wsel, punch_power_ff}, 8'h03);
        chk({6'h00, run, status[4]}, 8'h01);
        $display("test punch done");
        host_u.line_pulse(2);
        chk({2'h0, wsel, punch_power_ff, permit, run, attn, xmit}, 8'h01);
        $display("test init done");
        tally_and_finish();
    end
endmodule : tb_ptc_cmd_status
